// >>> hw/ihbi_host_port.sv
`timescale 1ns/10ps
`default_nettype none

module ihbi_host_port
   import ihbi_pkg::*;
(
   input  wire logic                                      clock,
   input  wire logic                                      reset,
   input  wire logic [IHBI_DATA_WIDTH-1:0]                host_data_in,
   output logic      [IHBI_DATA_WIDTH-1:0]                host_data_out,
   output logic                                           host_data_oe,
   input  wire logic                                      read_strobe_n,
   input  wire logic                                      write_strobe_n,
   input  wire logic                                      address_enable,
   input  wire logic [IHBI_ADDR_WIDTH-1:0]                host_address,
   output logic                                           floppy_dma_request,
   input  wire logic                                      dma_acknowledge_n,
   input  wire logic                                      port_dma_acknowledge_n,
   input  wire logic                                      terminal_count,
   input  wire ihbi_tc_mode_type                          tc_mode,
   input  wire logic                                      adapter_variant,
   input  wire logic [IHBI_ADDR_WIDTH-1:0]                floppy_base,
   input  wire logic [IHBI_PORTS-1:0][1:0]                com_select,
   input  wire logic [IHBI_PORTS-1:0][IHBI_IER_WIDTH-1:0] serial_pending,
   input  wire logic                                      floppy_core_irq,
   input  wire logic                                      floppy_core_request,
   input  wire logic                                      floppy_last_byte,
   input  wire logic [IHBI_DATA_WIDTH-1:0]                io_read_data,
   input  wire logic [IHBI_DATA_WIDTH-1:0]                dma_read_data,
   output logic      [IHBI_ADDR_WIDTH-1:0]                io_address,
   output logic      [IHBI_DATA_WIDTH-1:0]                write_data,
   output logic                                           io_read,
   output logic                                           io_write,
   output logic                                           dma_read,
   output logic                                           dma_write,
   output logic                                           terminal_count_event,
   output logic      [IHBI_PORTS-1:0][IHBI_IER_WIDTH-1:0] serial_irq_enable_reg,
   output logic      [IHBI_DATA_WIDTH-1:0]                drive_output_reg,
   output logic                                           irq3,
   output logic                                           irq4,
   output logic                                           first_serial_irq,
   output logic                                           second_serial_irq,
   output logic                                           floppy_irq
);

   function automatic logic [IHBI_ADDR_WIDTH-1:0] com_base(input logic [1:0] sel);
      case (sel)
         IHBI_COM1: com_base = IHBI_COM1_BASE;
         IHBI_COM2: com_base = IHBI_COM2_BASE;
         IHBI_COM3: com_base = IHBI_COM3_BASE;
         default:   com_base = IHBI_COM4_BASE;
      endcase
   endfunction : com_base
   function automatic logic window_hit(input logic [IHBI_ADDR_WIDTH-1:0] addr,
                                       input logic [IHBI_ADDR_WIDTH-1:0] base);
      window_hit = (addr & IHBI_WINDOW_MASK) == (base & IHBI_WINDOW_MASK);
   endfunction : window_hit
   function automatic logic low_group(input logic [1:0] sel);
      low_group = (sel == IHBI_COM1) || (sel == IHBI_COM3);
   endfunction : low_group

   logic [IHBI_SYNC_WIDTH-1:0] sync_bus;
   logic [IHBI_ADDR_WIDTH-1:0] addr;
   logic [IHBI_DATA_WIDTH-1:0] data;
   logic                       read_n, write_n, aen, dack_n, pdack_n, tc_pin;
   logic                       prev_read_n, prev_write_n, prev_dack_n;
   logic                       read_fall, write_fall, write_rise, dack_fall, io_hit;
   logic                       read_active, read_is_dma, write_active, write_is_dma;
   logic                       prev_core_request, request_clear;
   logic                       tc_asserted, tc_accepted, prev_tc_accepted;
   logic [IHBI_PORTS-1:0]      serial_request;

   // pins come from the host's domain, so everything is synchronised first
   ihbi_sync #(
      .WIDTH (IHBI_SYNC_WIDTH),
      .IDLE  (IHBI_SYNC_IDLE)
   ) u_sync (
      .clock    (clock),
      .reset    (reset),
      .async_in ({host_data_in, host_address, terminal_count, port_dma_acknowledge_n,
                  dma_acknowledge_n, address_enable, write_strobe_n, read_strobe_n}),
      .sync_out (sync_bus)
   );

   assign {data, addr, tc_pin, pdack_n, dack_n, aen, write_n, read_n} = sync_bus;

   always_ff @(posedge clock) begin
      if (reset) begin
         prev_read_n  <= 1'b1;
         prev_write_n <= 1'b1;
         prev_dack_n  <= 1'b1;
      end else begin
         prev_read_n  <= read_n;
         prev_write_n <= write_n;
         prev_dack_n  <= dack_n;
      end
   end

   assign read_fall  = prev_read_n & ~read_n;
   assign write_fall = prev_write_n & ~write_n;
   assign write_rise = ~prev_write_n & write_n;
   assign dack_fall  = prev_dack_n & ~dack_n;

   // a dma cycle (aen high) never selects an io register
   assign io_hit = ~aen & (window_hit(addr, floppy_base)
                   | window_hit(addr, com_base(com_select[0]))
                   | window_hit(addr, com_base(com_select[1])));

   always_ff @(posedge clock) begin
      if (reset) begin
         io_address <= '0;
      end else if (read_fall || write_fall) begin
         io_address <= addr;
      end
   end

   // read cycle: the strobe's leading edge decides io or dma, strobe release ends it
   always_ff @(posedge clock) begin
      if (reset) begin
         read_active <= 1'b0;
         read_is_dma <= 1'b0;
         io_read     <= 1'b0;
         dma_read    <= 1'b0;
      end else begin
         io_read  <= read_fall & io_hit;
         dma_read <= read_fall & ~dack_n;
         if (read_fall) begin
            read_active <= io_hit | ~dack_n;
            read_is_dma <= ~dack_n;
         end else if (read_n) begin
            read_active <= 1'b0;
         end
      end
   end

   // drive only while a claimed read is in progress
   always_ff @(posedge clock) begin
      if (reset) begin
         host_data_oe  <= 1'b0;
         host_data_out <= '0;
      end else begin
         host_data_oe  <= read_active & ~read_n;
         host_data_out <= read_is_dma ? dma_read_data : io_read_data;
      end
   end

   // write data is taken at the trailing edge, where the host guarantees it valid
   always_ff @(posedge clock) begin
      if (reset) begin
         write_active <= 1'b0;
         write_is_dma <= 1'b0;
         write_data   <= '0;
         io_write     <= 1'b0;
         dma_write    <= 1'b0;
      end else begin
         io_write  <= write_rise & write_active & ~write_is_dma;
         dma_write <= write_rise & write_active & write_is_dma;
         if (write_fall) begin
            write_active <= io_hit | ~dack_n;
            write_is_dma <= ~dack_n;
         end else if (write_rise) begin
            write_active <= 1'b0;
            write_data   <= data;
         end
      end
   end

   // drive output register: only the irq enable bit is used here
   always_ff @(posedge clock) begin
      if (reset) begin
         drive_output_reg <= IHBI_DOR_RESET;
      end else if (io_write && window_hit(io_address, floppy_base)
                   && io_address[$bits(IHBI_DOR_OFFSET)-1:0] == IHBI_DOR_OFFSET) begin
         drive_output_reg <= write_data;
      end
   end

   // the floppy core's request rising starts a request; the last byte ends it at an acknowledge fall or a read strobe under acknowledge
   assign request_clear = floppy_last_byte & (dack_fall | (read_fall & ~prev_dack_n));
   always_ff @(posedge clock) begin
      if (reset) begin
         prev_core_request  <= 1'b0;
         floppy_dma_request <= 1'b0;
      end else begin
         prev_core_request  <= floppy_core_request;
         floppy_dma_request <= (floppy_core_request & ~prev_core_request)
                               | (floppy_dma_request & ~request_clear);
      end
   end

   assign tc_asserted = (tc_mode == IHBI_TC_COMPAT) ? ~tc_pin : tc_pin;
   assign tc_accepted = tc_asserted & (~dack_n | ~pdack_n);

   always_ff @(posedge clock) begin
      if (reset) begin
         prev_tc_accepted     <= 1'b0;
         terminal_count_event <= 1'b0;
      end else begin
         prev_tc_accepted     <= tc_accepted;
         terminal_count_event <= tc_accepted & ~prev_tc_accepted;
      end
   end

   genvar port;
   generate
      for (port = 0; port < IHBI_PORTS; port++) begin : g_serial
         always_ff @(posedge clock) begin
            if (reset) begin
               serial_irq_enable_reg[port] <= IHBI_IER_RESET;
            end else if (io_write && window_hit(io_address, com_base(com_select[port]))
                         && io_address[$bits(IHBI_IER_OFFSET)-1:0] == IHBI_IER_OFFSET) begin
               serial_irq_enable_reg[port] <= write_data[IHBI_IER_WIDTH-1:0];
            end
         end
         // pending clears in the uart once serviced, so the request follows it
         assign serial_request[port] = |(serial_pending[port]
                                         & serial_irq_enable_reg[port]);
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (reset) begin
         irq3              <= 1'b0;
         irq4              <= 1'b0;
         first_serial_irq  <= 1'b0;
         second_serial_irq <= 1'b0;
         floppy_irq        <= 1'b0;
      end else begin
         irq4 <= ~adapter_variant & ((serial_request[0] & low_group(com_select[0]))
                                   | (serial_request[1] & low_group(com_select[1])));
         irq3 <= ~adapter_variant & ((serial_request[0] & ~low_group(com_select[0]))
                                   | (serial_request[1] & ~low_group(com_select[1])));
         first_serial_irq  <= adapter_variant & serial_request[0];
         second_serial_irq <= adapter_variant & serial_request[1];
         floppy_irq <= floppy_core_irq & drive_output_reg[IHBI_DOR_IRQ_ENABLE_BIT];
      end
   end

   AST_BUS_FLOATS_IDLE: assert property (@(posedge clock) disable iff (reset)
      (read_n && prev_read_n) |=> !host_data_oe)
      else $error("data bus driven with no read in progress");
   AST_AEN_BLOCKS_IO: assert property (@(posedge clock) disable iff (reset)
      (read_fall && aen) |=> !io_read)
      else $error("io read issued during a dma cycle");
   AST_ADDRESS_CAPTURED: assert property (@(posedge clock) disable iff (reset)
      (read_fall || write_fall) |=> (io_address == $past(addr)))
      else $error("address not captured on strobe leading edge");
   AST_REQUEST_CLEARS: assert property (@(posedge clock) disable iff (reset)
      (floppy_last_byte && dack_fall && !(floppy_core_request && !prev_core_request))
      |=> !floppy_dma_request)
      else $error("dma request not cleared on last byte");
   AST_DMA_NEEDS_ACK: assert property (@(posedge clock) disable iff (reset)
      (dma_read || dma_write) |-> ($past(!dack_n) || $past(write_is_dma)))
      else $error("dma transfer without acknowledge");
   AST_TC_NEEDS_ACK: assert property (@(posedge clock) disable iff (reset)
      terminal_count_event |-> $past(!dack_n || !pdack_n))
      else $error("terminal count taken without acknowledge");
   AST_TC_POLARITY: assert property (@(posedge clock) disable iff (reset)
      ($past(tc_mode) == IHBI_TC_COMPAT && $past(tc_pin)) |-> !terminal_count_event)
      else $error("terminal count taken at wrong polarity");
   AST_ROUTE_IRQ4: assert property (@(posedge clock) disable iff (reset)
      (!adapter_variant && serial_request[0] && com_select[0] == IHBI_COM3) |=> irq4)
      else $error("com3 interrupt not routed to irq4");
   AST_ROUTE_IRQ3: assert property (@(posedge clock) disable iff (reset)
      (!adapter_variant && serial_request[1] && com_select[1] == IHBI_COM2) |=> irq3)
      else $error("com2 interrupt not routed to irq3");
   AST_IRQ_GATED: assert property (@(posedge clock) disable iff (reset)
      (serial_irq_enable_reg == '0) |=> !(irq3 || irq4 || first_serial_irq || second_serial_irq))
      else $error("serial interrupt with no source enabled");
   AST_ADAPTER_PINS: assert property (@(posedge clock) disable iff (reset)
      adapter_variant |=> (!irq3 && !irq4 && first_serial_irq == $past(serial_request[0])))
      else $error("adapter variant used shared interrupt pins");
   AST_FLOPPY_IRQ_GATE: assert property (@(posedge clock) disable iff (reset)
      !drive_output_reg[IHBI_DOR_IRQ_ENABLE_BIT] |=> !floppy_irq)
      else $error("floppy interrupt while disabled");

endmodule : ihbi_host_port

`default_nettype wire

// >>> hw/ihbi_pkg.sv
package ihbi_pkg;

   localparam int IHBI_DATA_WIDTH = 8;
   localparam int IHBI_ADDR_WIDTH = 10;
   localparam int IHBI_PORTS      = 2;
   localparam int IHBI_IER_WIDTH  = 4;

   // bit positions in the synchroniser vector
   localparam int IHBI_SYNC_READ  = 0;
   localparam int IHBI_SYNC_WRITE = 1;
   localparam int IHBI_SYNC_AEN   = 2;
   localparam int IHBI_SYNC_DACK  = 3;
   localparam int IHBI_SYNC_PDACK = 4;
   localparam int IHBI_SYNC_TC    = 5;
   localparam int IHBI_SYNC_ADDR  = 6;
   localparam int IHBI_SYNC_DATA  = IHBI_SYNC_ADDR + IHBI_ADDR_WIDTH;
   localparam int IHBI_SYNC_WIDTH = IHBI_SYNC_DATA + IHBI_DATA_WIDTH;
   // strobes and acknowledges idle high, everything else low
   localparam logic [IHBI_SYNC_WIDTH-1:0] IHBI_SYNC_IDLE = 24'h00_001b;

   // serial port base addresses
   localparam logic [1:0] IHBI_COM1 = 2'h0;
   localparam logic [1:0] IHBI_COM2 = 2'h1;
   localparam logic [1:0] IHBI_COM3 = 2'h2;
   localparam logic [1:0] IHBI_COM4 = 2'h3;
   localparam logic [IHBI_ADDR_WIDTH-1:0] IHBI_COM1_BASE = 10'h3f8;
   localparam logic [IHBI_ADDR_WIDTH-1:0] IHBI_COM2_BASE = 10'h2f8;
   localparam logic [IHBI_ADDR_WIDTH-1:0] IHBI_COM3_BASE = 10'h3e8;
   localparam logic [IHBI_ADDR_WIDTH-1:0] IHBI_COM4_BASE = 10'h2e8;
   // serial and floppy windows are eight registers wide
   localparam logic [IHBI_ADDR_WIDTH-1:0] IHBI_WINDOW_MASK = 10'h3f8;
   localparam logic [2:0] IHBI_IER_OFFSET = 3'h1;
   localparam logic [2:0] IHBI_DOR_OFFSET = 3'h2;
   localparam int IHBI_DOR_IRQ_ENABLE_BIT = 3;
   localparam logic [IHBI_DATA_WIDTH-1:0] IHBI_DOR_RESET = 8'h00;
   localparam logic [IHBI_IER_WIDTH-1:0]  IHBI_IER_RESET = 4'h0;

   typedef enum logic [1:0] {
      IHBI_TC_AT,
      IHBI_TC_MODEL30,
      IHBI_TC_COMPAT
   } ihbi_tc_mode_type;

endpackage : ihbi_pkg

// >>> hw/ihbi_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser; stage one feeds stage two only
module ihbi_sync #(
   parameter int                WIDTH = 1,
   parameter logic [WIDTH-1:0] IDLE  = '0
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   always_ff @(posedge clock) begin
      if (reset) begin
         stage_one <= IDLE;
         sync_out  <= IDLE;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule : ihbi_sync

`default_nettype wire

// >>> hw/ihbi_note_unused.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> sim/ihbi_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// host processor and system dma controller seen from the device pins
module ihbi_host_model
   import ihbi_pkg::*;
(
   input  wire logic                       clock,
   input  wire logic [IHBI_DATA_WIDTH-1:0] dev_data,
   input  wire logic                       dev_oe,
   output logic      [IHBI_DATA_WIDTH-1:0] bus_data,
   output logic                            read_strobe_n,
   output logic                            write_strobe_n,
   output logic                            address_enable,
   output logic      [IHBI_ADDR_WIDTH-1:0] host_address,
   output logic                            dma_acknowledge_n
);
   logic [IHBI_DATA_WIDTH-1:0] host_drive = 8'h00;
   logic                       host_oe    = 1'b0;
   logic [IHBI_DATA_WIDTH-1:0] last       = 8'h00;

   initial begin
      read_strobe_n     = 1'b1;
      write_strobe_n    = 1'b1;
      address_enable    = 1'b0;
      host_address      = 10'h000;
      dma_acknowledge_n = 1'b1;
   end

   // no pull-up: a released bus toggles so a stale value never looks valid
   always_comb bus_data = dev_oe ? dev_data : (host_oe ? host_drive : ~last);
   always @(posedge clock) last <= bus_data;

   task automatic access(input logic rd, input logic aen, input logic [IHBI_ADDR_WIDTH-1:0] a,
                         input logic [IHBI_DATA_WIDTH-1:0] d, input int hold,
                         output logic [IHBI_DATA_WIDTH-1:0] q);
      @(posedge clock);
      address_enable <= aen;
      host_address   <= a;
      host_drive     <= d;
      host_oe        <= !rd;
      read_strobe_n  <= !rd;
      write_strobe_n <= rd;
      repeat (hold) @(posedge clock);
      q = bus_data;
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
      // write data outlives the strobe so the trailing-edge capture sees it
      repeat (3) @(posedge clock);
      host_oe <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
   endtask : access

   task automatic ack(input logic v);
      @(posedge clock);
      dma_acknowledge_n <= v;
   endtask : ack
endmodule : ihbi_host_model

`default_nettype wire

// >>> sim/isa_host_bus_interface_tb.sv
`timescale 1ns/10ps
`default_nettype none

module isa_host_bus_interface_tb
   import ihbi_pkg::*;
;
   logic clock = 1'b0, reset = 1'b1, host_data_oe, read_strobe_n, write_strobe_n;
   logic address_enable, floppy_dma_request, dma_acknowledge_n, port_dma_acknowledge_n;
   logic terminal_count, adapter_variant, floppy_core_irq, floppy_core_request;
   logic floppy_last_byte, io_read, io_write, dma_read, dma_write, terminal_count_event;
   logic irq3, irq4, first_serial_irq, second_serial_irq, floppy_irq;
   logic [IHBI_DATA_WIDTH-1:0] host_data_in, host_data_out, io_read_data, dma_read_data;
   logic [IHBI_DATA_WIDTH-1:0] write_data, drive_output_reg, d, q;
   logic [IHBI_ADDR_WIDTH-1:0] host_address, floppy_base, io_address, cb;
   logic [IHBI_PORTS-1:0][1:0] com_select;
   logic [IHBI_PORTS-1:0][IHBI_IER_WIDTH-1:0] serial_pending, serial_irq_enable_reg, ier_exp;
   ihbi_tc_mode_type tc_mode;
   int seed, n_mismatch, num_checks, k;
   int n_iord, n_iowr, n_dmard, n_dmawr, n_tc, n_oe;

   ihbi_host_port u_dut (
      .clock, .reset, .host_data_in, .host_data_out, .host_data_oe, .read_strobe_n,
      .write_strobe_n, .address_enable, .host_address, .floppy_dma_request,
      .dma_acknowledge_n, .port_dma_acknowledge_n, .terminal_count, .tc_mode,
      .adapter_variant, .floppy_base, .com_select, .serial_pending, .floppy_core_irq,
      .floppy_core_request, .floppy_last_byte, .io_read_data, .dma_read_data, .io_address,
      .write_data, .io_read, .io_write, .dma_read, .dma_write, .terminal_count_event,
      .serial_irq_enable_reg, .drive_output_reg, .irq3, .irq4, .first_serial_irq,
      .second_serial_irq, .floppy_irq
   );
   ihbi_host_model u_host (
      .clock, .dev_data(host_data_out), .dev_oe(host_data_oe), .bus_data(host_data_in),
      .read_strobe_n, .write_strobe_n, .address_enable, .host_address, .dma_acknowledge_n
   );

   always #5 clock = ~clock;

   always @(posedge clock) begin
      n_iord  += int'(io_read === 1'b1);
      n_iowr  += int'(io_write === 1'b1);
      n_dmard += int'(dma_read === 1'b1);
      n_dmawr += int'(dma_write === 1'b1);
      n_tc    += int'(terminal_count_event === 1'b1);
      n_oe    += int'(host_data_oe === 1'b1);
   end

   function automatic logic [IHBI_ADDR_WIDTH-1:0] com_base(input logic [1:0] c);
      case (c)
         IHBI_COM1: return IHBI_COM1_BASE;
         IHBI_COM2: return IHBI_COM2_BASE;
         IHBI_COM3: return IHBI_COM3_BASE;
         default:   return IHBI_COM4_BASE;
      endcase
   endfunction : com_base

   // {irq4, irq3, second, first}
   function automatic logic [3:0] irq_exp(input logic ad);
      logic [3:0] r;
      logic       hit;
      r = 4'h0;
      for (int p = 0; p < IHBI_PORTS; p++) begin
         hit = |(serial_pending[p] & ier_exp[p]);
         if (ad) r[p] = hit;
         else if (com_select[p][0]) r[2] = r[2] | hit;
         else r[3] = r[3] | hit;
      end
      return r;
   endfunction : irq_exp

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : settle

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      $display("watchdog expired");
      stop_test();
   end

   initial begin
      seed = 37;
      {io_read_data, dma_read_data, com_select, serial_pending, ier_exp} = '0;
      {adapter_variant, floppy_core_irq, floppy_core_request, floppy_last_byte} = 4'h0;
      {terminal_count, port_dma_acknowledge_n} = 2'b01;
      tc_mode = IHBI_TC_AT;
      floppy_base = 10'h3f0;
      settle(3);
      reset <= 1'b0;
      check("oe", host_data_oe, 1'b0);
      check("ier", serial_irq_enable_reg, 8'h00);
      check("irq", {irq4, irq3, second_serial_irq, first_serial_irq}, 4'h0);
      for (int c = 0; c < 4; c++) begin
         com_select <= {2'(3 - c), 2'(c)};
         for (int p = 0; p < IHBI_PORTS; p++) begin
            // even passes enable every source so the com2/com3 routes fire on pass 2
            d = (c % 2 == 0) ? 8'h0f : 8'($random(seed));
            cb = com_base(p ? 2'(3 - c) : 2'(c)) | 10'(IHBI_IER_OFFSET);
            u_host.access(1'b0, 1'b0, cb, d, 4, q);
            ier_exp[p] = d[3:0];
            check("write_data", write_data, d);
         end
         check("ier", serial_irq_enable_reg, ier_exp);
         serial_pending <= 8'($random(seed)) | 8'h11;
         for (int ad = 0; ad < 2; ad++) begin
            adapter_variant <= 1'(ad);
            settle(3);
            check("irq", {irq4, irq3, second_serial_irq, first_serial_irq},
                  irq_exp(1'(ad)));
         end
         serial_pending <= 8'h00;
         settle(3);
         check("irq idle", {irq4, irq3, second_serial_irq, first_serial_irq}, 4'h0);
      end
      // mid-run reset with every source pending: enables must come back cleared
      serial_pending <= 8'hff;
      reset <= 1'b1;
      settle(3);
      reset <= 1'b0;
      ier_exp = '0;
      settle(2);
      check("ier reset", serial_irq_enable_reg, ier_exp);
      check("irq reset", {irq4, irq3, second_serial_irq, first_serial_irq}, 4'h0);
      serial_pending <= 8'h00;
      cb = com_base(com_select[0]);
      u_host.access(1'b0, 1'b1, cb | 10'h001, {4'h0, ~ier_exp[0]}, 4, q);
      check("ier aen", serial_irq_enable_reg, ier_exp);
      check("io writes", n_iowr, 8);
      $display("serial irq test done");
      io_read_data <= 8'($random(seed));
      u_host.access(1'b1, 1'b0, cb, 8'h00, 6, q);
      check("read data", q, io_read_data);
      check("io_address", io_address, cb);
      check("oe after", host_data_oe, 1'b0);
      k = n_oe;
      u_host.access(1'b1, 1'b0, 10'h100, 8'h00, 6, q);
      u_host.access(1'b1, 1'b1, cb, 8'h00, 6, q);
      check("stray drive", n_oe - k, 0);
      check("io reads", n_iord, 1);
      check("dma reads", n_dmard, 0);
      $display("read test done");
      floppy_core_irq <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         d = 8'($random(seed));
         d[IHBI_DOR_IRQ_ENABLE_BIT] = i[0];
         u_host.access(1'b0, 1'b0, floppy_base | 10'(IHBI_DOR_OFFSET), d, 4, q);
         check("dor", drive_output_reg, d);
         check("floppy irq", floppy_irq, d[IHBI_DOR_IRQ_ENABLE_BIT]);
      end
      $display("floppy irq test done");
      floppy_core_request <= 1'b1;
      settle(4);
      check("drq", floppy_dma_request, 1'b1);
      u_host.ack(1'b0);
      settle(4);
      check("drq mid", floppy_dma_request, 1'b1);
      d = 8'($random(seed));
      u_host.access(1'b0, 1'b1, floppy_base, d, 4, q);
      check("dma writes", n_dmawr, 1);
      check("dma data", write_data, d);
      floppy_last_byte <= 1'b1;
      dma_read_data <= 8'($random(seed));
      u_host.access(1'b1, 1'b1, floppy_base, 8'h00, 6, q);
      check("dma read", q, dma_read_data);
      check("drq demand", floppy_dma_request, 1'b0);
      check("io reads", n_iord, 1);
      u_host.ack(1'b1);
      floppy_core_request <= 1'b0;
      settle(3);
      floppy_core_request <= 1'b1;
      settle(4);
      check("drq", floppy_dma_request, 1'b1);
      u_host.ack(1'b0);
      settle(4);
      check("drq ack", floppy_dma_request, 1'b0);
      u_host.ack(1'b1);
      $display("dma test done");
      for (int m = 0; m < 3; m++) begin
         tc_mode <= ihbi_tc_mode_type'(m);
         terminal_count <= (m == 2);
         settle(4);
         for (int a = 0; a < 2; a++) begin
            k = n_tc;
            port_dma_acknowledge_n <= !a;
            settle(4);
            terminal_count <= (m != 2);
            settle(6);
            terminal_count <= (m == 2);
            port_dma_acknowledge_n <= 1'b1;
            settle(4);
            check("tc events", n_tc - k, a);
         end
      end
      $display("terminal count test done");
      stop_test();
   end
endmodule : isa_host_bus_interface_tb

`default_nettype wire
